// file: rtl/ebrh_pkg.sv
package ebrh_pkg;
   // timing
   localparam int SYS_CLK_NS = 40;
   localparam int BUS_CLK_NS = 320;
   localparam int DIV_CYC = BUS_CLK_NS / SYS_CLK_NS;
   localparam logic [2:0] DIV_LAST = 3'(DIV_CYC - 1);
   localparam logic [2:0] DIV_HALF = 3'(DIV_CYC / 2);
   localparam int HOLD_SETUP_NS = 20;
   localparam int HOLD_SETUP_CYC = (HOLD_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int RDY_LOW_NS = 65;
   localparam int RDY_LOW_CYC = (RDY_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SYNC_W = 18;

   // register offsets
   localparam logic [5:0] OFF_CTRL = 6'h00;
   localparam logic [5:0] OFF_ADDR = 6'h04;
   localparam logic [5:0] OFF_WDATA = 6'h08;
   localparam logic [5:0] OFF_CMD = 6'h0c;
   localparam logic [5:0] OFF_STATUS = 6'h10;
   localparam logic [5:0] OFF_RDATA = 6'h14;

   // fields
   localparam int CMD_START = 0;
   localparam int CMD_WRITE = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_HOLD_ACK = 1;
   localparam int ST_BUS_REQ = 2;
   localparam int ST_STATE_LSB = 4;
   localparam logic [7:0] CTRL_RST = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ctrl[7:0] layout
   typedef struct packed {
      logic [3:0] memory_cycle_wait_count;
      logic ready_en;
      logic rw_delay;
      logic tristate_wait_option;
      logic mux_mode;
   } ebrh_cfg_s;

   typedef struct packed {
      logic ale;
      logic rd_n;
      logic wr_n;
      logic [15:0] addr;
      logic [15:0] dout;
      logic dout_oe_n;
   } ebrh_pins_s;

   localparam ebrh_pins_s PINS_RST = '{1'b0, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1};

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_DELAY = 4'h3,
      ST_CMD = 4'h2,
      ST_RDY = 4'h6,
      ST_MUXW = 4'h7,
      ST_TRIW = 4'h5,
      ST_HOLDA = 4'hc,
      ST_REGAIN = 4'hd
   } ebrh_state_e;
endpackage

// file: rtl/ebrh_sync.sv
`timescale 1ns/1ps
module ebrh_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   input wire logic [WIDTH-1:0] i_rst_val,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // two flops, first read only by second
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg & ~i_rst_val | sync_reg & i_rst_val;
endmodule

// file: rtl/ebrh_top.sv
`timescale 1ns/1ps
module ebrh_top (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // axi4-lite slave
   input wire logic [5:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [5:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // external bus pins
   output logic o_bus_clock_output,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_ctl_oe_n,
   output logic [15:0] o_addr,
   output logic o_addr_oe_n,
   input wire logic [15:0] i_data,
   output logic [15:0] o_data,
   output logic o_data_oe_n,
   input wire logic i_ready_n,
   // arbitration
   input wire logic i_hold_n,
   output logic o_hold_acknowledge_out,
   output logic o_bus_request_out
);
   logic [ebrh_pkg::SYNC_W-1:0] sync_out;
   logic rdy_s;
   logic hold_s;
   logic [15:0] din_s;

   ebrh_sync #(.WIDTH(ebrh_pkg::SYNC_W)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_async({i_hold_n, i_ready_n, i_data}),
      .i_rst_val('1),
      .o_sync(sync_out)
   );
   assign hold_s = ~sync_out[17];
   assign rdy_s = sync_out[16];
   assign din_s = sync_out[15:0];

   // register file
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] stb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ebrh_pkg::ebrh_cfg_s cfg_reg, cfg_next;
   logic [15:0] addr_reg, addr_next;
   logic [15:0] wdata_reg, wdata_next;
   logic wr_req_reg, wr_req_next;
   logic go;
   logic [5:0] aw_reg, aw_next;
   logic aw_have_reg, aw_have_next;
   logic [31:0] w_reg, w_next;
   logic [3:0] ws_reg, ws_next;
   logic w_have_reg, w_have_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [15:0] bus_rd_reg, bus_rd_next;
   logic pend_reg, pend_next;
   logic ack_reg, ack_next;
   logic bus_req_reg, bus_req_next;
   ebrh_pkg::ebrh_state_e st_reg, st_next;

   assign o_s_axi_awready = ~aw_have_reg & ~bvalid_reg;
   assign o_s_axi_wready = ~w_have_reg & ~bvalid_reg;
   assign o_s_axi_arready = ~rvalid_reg;
   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp = bresp_reg;
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;

   always_comb begin
      logic [31:0] m;
      m = merge(32'h0, w_reg, ws_reg);
      cfg_next = cfg_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      wr_req_next = wr_req_reg;
      go = 1'b0;
      aw_next = aw_reg;
      aw_have_next = aw_have_reg;
      w_next = w_reg;
      ws_next = ws_reg;
      w_have_next = w_have_reg;
      bvalid_next = bvalid_reg & ~i_s_axi_bready;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg & ~i_s_axi_rready;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (i_s_axi_awvalid && o_s_axi_awready) begin
         aw_next = i_s_axi_awaddr;
         aw_have_next = 1'b1;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
         w_next = i_s_axi_wdata;
         ws_next = i_s_axi_wstrb;
         w_have_next = 1'b1;
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = ebrh_pkg::RESP_OKAY;
         unique case (aw_reg)
            ebrh_pkg::OFF_CTRL: cfg_next = 8'(merge({24'h0, cfg_reg}, w_reg, ws_reg));
            ebrh_pkg::OFF_ADDR: addr_next = 16'(merge({16'h0, addr_reg}, w_reg, ws_reg));
            ebrh_pkg::OFF_WDATA: wdata_next = 16'(merge({16'h0, wdata_reg}, w_reg, ws_reg));
            ebrh_pkg::OFF_CMD: begin
               // start ignored while a cycle is pending
               if (m[ebrh_pkg::CMD_START] && !pend_reg) begin
                  go = 1'b1;
                  wr_req_next = m[ebrh_pkg::CMD_WRITE];
               end
            end
            ebrh_pkg::OFF_STATUS, ebrh_pkg::OFF_RDATA: ;
            default: bresp_next = ebrh_pkg::RESP_SLVERR;
         endcase
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = ebrh_pkg::RESP_OKAY;
         unique case (i_s_axi_araddr)
            ebrh_pkg::OFF_CTRL: rdata_next = {24'h0, cfg_reg};
            ebrh_pkg::OFF_ADDR: rdata_next = {16'h0, addr_reg};
            ebrh_pkg::OFF_WDATA: rdata_next = {16'h0, wdata_reg};
            ebrh_pkg::OFF_CMD: rdata_next = {30'h0, wr_req_reg, 1'b0};
            ebrh_pkg::OFF_STATUS: rdata_next = {24'h0, st_reg, 1'b0, bus_req_reg, ack_reg,
                                                pend_reg};
            ebrh_pkg::OFF_RDATA: rdata_next = {16'h0, bus_rd_reg};
            default: begin
               rdata_next = 32'h0;
               rresp_next = ebrh_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cfg_reg <= ebrh_pkg::CTRL_RST;
         addr_reg <= 16'h0000;
         wdata_reg <= 16'h0000;
         wr_req_reg <= 1'b0;
         aw_reg <= 6'h00;
         aw_have_reg <= 1'b0;
         w_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
         w_have_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
      end else begin
         cfg_reg <= cfg_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         wr_req_reg <= wr_req_next;
         aw_reg <= aw_next;
         aw_have_reg <= aw_have_next;
         w_reg <= w_next;
         ws_reg <= ws_next;
         w_have_reg <= w_have_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // bus clock divider and cycle engine
   logic [2:0] div_reg, div_next;
   logic bclk_reg, bclk_next;
   logic tick;
   logic [3:0] wcnt_reg, wcnt_next;
   logic float_reg, float_next;
   ebrh_pkg::ebrh_pins_s pins_reg, pins_next;

   assign tick = (div_reg == ebrh_pkg::DIV_LAST);

   always_comb begin
      logic done;
      done = 1'b0;
      div_next = tick ? 3'h0 : div_reg + 3'h1;
      bclk_next = (div_next < ebrh_pkg::DIV_HALF);
      st_next = st_reg;
      wcnt_next = wcnt_reg;
      pend_next = pend_reg | go;
      ack_next = ack_reg;
      bus_req_next = bus_req_reg;
      float_next = float_reg;
      pins_next = pins_reg;
      bus_rd_next = bus_rd_reg;
      if (tick) begin
         unique case (st_reg)
            ebrh_pkg::ST_IDLE: begin
               if (hold_s) begin
                  st_next = ebrh_pkg::ST_HOLDA;
                  ack_next = 1'b1;
                  float_next = 1'b1;
               end else if (pend_reg) begin
                  st_next = ebrh_pkg::ST_ADDR;
                  pins_next.ale = 1'b1;
                  pins_next.addr = addr_reg;
                  pins_next.dout = cfg_reg.mux_mode ? addr_reg : wdata_reg;
                  pins_next.dout_oe_n = ~(cfg_reg.mux_mode | wr_req_reg);
               end
            end
            ebrh_pkg::ST_ADDR: begin
               pins_next.ale = 1'b0;
               pins_next.dout = wdata_reg;
               pins_next.dout_oe_n = ~wr_req_reg;
               wcnt_next = 4'h0;
               if (cfg_reg.rw_delay) begin
                  st_next = ebrh_pkg::ST_DELAY;
               end else begin
                  st_next = ebrh_pkg::ST_CMD;
                  pins_next.rd_n = wr_req_reg;
                  pins_next.wr_n = ~wr_req_reg;
               end
            end
            ebrh_pkg::ST_DELAY: begin
               st_next = ebrh_pkg::ST_CMD;
               pins_next.rd_n = wr_req_reg;
               pins_next.wr_n = ~wr_req_reg;
            end
            ebrh_pkg::ST_CMD: begin
               if (wcnt_reg != cfg_reg.memory_cycle_wait_count) begin
                  wcnt_next = wcnt_reg + 4'h1;
               end else if (cfg_reg.ready_en && rdy_s) begin
                  st_next = ebrh_pkg::ST_RDY;
               end else begin
                  done = 1'b1;
               end
            end
            ebrh_pkg::ST_RDY: begin
               done = !(cfg_reg.ready_en && rdy_s);
            end
            ebrh_pkg::ST_MUXW: begin
               st_next = cfg_reg.tristate_wait_option ? ebrh_pkg::ST_TRIW
                                                      : ebrh_pkg::ST_IDLE;
            end
            ebrh_pkg::ST_TRIW: begin
               st_next = ebrh_pkg::ST_IDLE;
            end
            ebrh_pkg::ST_HOLDA: begin
               bus_req_next = pend_reg;
               if (!hold_s) begin
                  st_next = ebrh_pkg::ST_REGAIN;
                  ack_next = 1'b0;
                  bus_req_next = 1'b0;
               end
            end
            ebrh_pkg::ST_REGAIN: begin
               float_next = 1'b0;
               st_next = ebrh_pkg::ST_IDLE;
            end
            default: st_next = ebrh_pkg::ST_IDLE;
         endcase
         if (done) begin
            // the responder may now drop ready on the strobe rise
            pins_next.rd_n = 1'b1;
            pins_next.wr_n = 1'b1;
            pins_next.dout_oe_n = 1'b1;
            if (!wr_req_reg) begin
               bus_rd_next = din_s;
            end
            pend_next = 1'b0;
            if (cfg_reg.mux_mode) begin
               st_next = ebrh_pkg::ST_MUXW;
            end else if (cfg_reg.tristate_wait_option) begin
               st_next = ebrh_pkg::ST_TRIW;
            end else begin
               st_next = ebrh_pkg::ST_IDLE;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_reg <= 3'h0;
         bclk_reg <= 1'b1;
         st_reg <= ebrh_pkg::ST_IDLE;
         wcnt_reg <= 4'h0;
         pend_reg <= 1'b0;
         ack_reg <= 1'b0;
         bus_req_reg <= 1'b0;
         float_reg <= 1'b0;
         pins_reg <= ebrh_pkg::PINS_RST;
         bus_rd_reg <= 16'h0000;
      end else begin
         div_reg <= div_next;
         bclk_reg <= bclk_next;
         st_reg <= st_next;
         wcnt_reg <= wcnt_next;
         pend_reg <= pend_next;
         ack_reg <= ack_next;
         bus_req_reg <= bus_req_next;
         float_reg <= float_next;
         pins_reg <= pins_next;
         bus_rd_reg <= bus_rd_next;
      end
   end

   assign o_bus_clock_output = bclk_reg;
   assign o_ale = pins_reg.ale;
   assign o_rd_n = pins_reg.rd_n;
   assign o_wr_n = pins_reg.wr_n;
   assign o_addr = pins_reg.addr;
   assign o_data = pins_reg.dout;
   assign o_ctl_oe_n = float_reg;
   assign o_addr_oe_n = float_reg;
   assign o_data_oe_n = float_reg | pins_reg.dout_oe_n;
   assign o_hold_acknowledge_out = ack_reg;
   assign o_bus_request_out = bus_req_reg;

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   sequence mux_tri_gap_s;
      st_reg == ebrh_pkg::ST_MUXW ##8 st_reg == ebrh_pkg::ST_TRIW ##8 st_reg == ebrh_pkg::ST_IDLE;
   endsequence

   rdy_wait_a: assert property (
      st_reg == ebrh_pkg::ST_RDY && tick && rdy_s && cfg_reg.ready_en
      |=> st_reg == ebrh_pkg::ST_RDY && (pins_reg.rd_n ^ pins_reg.wr_n))
      else $error("ready high did not stretch the cycle");
   rdy_end_a: assert property (
      st_reg == ebrh_pkg::ST_RDY && tick && !rdy_s
      |=> pins_reg.rd_n && pins_reg.wr_n && !pend_reg && st_reg != ebrh_pkg::ST_RDY)
      else $error("ready low did not end the cycle");
   prog_wait_a: assert property (
      st_reg == ebrh_pkg::ST_CMD && tick && wcnt_reg != cfg_reg.memory_cycle_wait_count
      |=> st_reg == ebrh_pkg::ST_CMD && wcnt_reg == $past(wcnt_reg) + 4'h1)
      else $error("programmed waitstates cut short");
   rw_delay_a: assert property (
      st_reg == ebrh_pkg::ST_ADDR && tick && cfg_reg.rw_delay
      |=> pins_reg.rd_n && pins_reg.wr_n ##8 !(pins_reg.rd_n && pins_reg.wr_n))
      else $error("strobe leading edge not delayed");
   mux_gap_a: assert property (
      st_reg inside {ebrh_pkg::ST_CMD, ebrh_pkg::ST_RDY} && tick && pins_next.rd_n
      && pins_next.wr_n && cfg_reg.mux_mode && cfg_reg.tristate_wait_option |=> mux_tri_gap_s)
      else $error("multiplexed gap is not two bus clocks");
   hold_grant_a: assert property (
      $rose(ack_reg) |-> $past(st_reg) == ebrh_pkg::ST_IDLE && pins_reg.rd_n && pins_reg.wr_n)
      else $error("hold granted during a cycle");
   bus_req_late_a: assert property (
      bus_req_reg |-> ack_reg)
      else $error("bus request before hold acknowledge");
   regain_start_a: assert property (
      st_reg == ebrh_pkg::ST_HOLDA && tick && !hold_s
      |=> st_reg == ebrh_pkg::ST_REGAIN && !ack_reg && !bus_req_reg)
      else $error("regain did not follow hold release");
   arb_edge_a: assert property (
      ($changed(ack_reg) || $changed(bus_req_reg)) |-> $rose(bclk_reg))
      else $error("arbitration outputs moved off a bus clock edge");
   float_bus_a: assert property (
      ack_reg |-> o_ctl_oe_n && o_addr_oe_n && o_data_oe_n)
      else $error("bus driven while hold acknowledged");
endmodule

// file: verif/ebrh_partner.sv
`timescale 1ns/1ps
module ebrh_partner (
   // clock
   input wire logic i_clk_sys,
   // strobes from the device
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   // bench controls
   input wire logic [7:0] i_waits,
   input wire logic [15:0] i_rd_val,
   input wire logic i_hold_req,
   // lines towards the device
   output logic [15:0] o_data,
   output logic o_ready_n,
   output logic o_hold_n
);
   logic [7:0] cnt_reg;

   initial begin
      cnt_reg = 8'h00;
      o_data = 16'h0000;
      o_ready_n = 1'b1;
      o_hold_n = 1'b1;
   end

   always @(posedge i_clk_sys) begin
      // ready low after the set delay, kept low until the strobe rises
      if (!(i_rd_n && i_wr_n)) begin
         cnt_reg <= cnt_reg + 8'h01;
         o_ready_n <= !(cnt_reg >= i_waits);
      end else begin
         cnt_reg <= 8'h00;
         o_ready_n <= 1'b1;
      end
      // read data only while selected, else a changing pattern
      o_data <= !i_rd_n ? i_rd_val : ~o_data;
      // hold changes just after an edge, well ahead of the next tick
      o_hold_n <= !i_hold_req;
   end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
   logic i_clk_sys, i_sys_rst, awvalid, wvalid, bready, arvalid, rready, hold_req;
   logic awready, wready, bvalid, arready, rvalid, bclk, ale, rd_n, wr_n;
   logic ctl_oe_n, addr_oe_n, data_oe_n, ready_n, hold_n, hold_ack, bus_req;
   logic p_ale, p_stb, p_ack, p_req, p_bclk, p_oe, s_wr;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [15:0] addr, dout, din, rd_val, a_ale, d_ale, d_stb;
   logic [7:0] pw;
   int fails, total_checks, cyc, t_ale, t_sf, t_sr, t_hr, t_hf, t_oe, n_ale, viol;

   ebrh_top u_ebrh_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_bus_clock_output(bclk),
      .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ctl_oe_n(ctl_oe_n), .o_addr(addr),
      .o_addr_oe_n(addr_oe_n), .i_data(din), .o_data(dout), .o_data_oe_n(data_oe_n),
      .i_ready_n(ready_n), .i_hold_n(hold_n), .o_hold_acknowledge_out(hold_ack),
      .o_bus_request_out(bus_req));
   ebrh_partner u_ebrh_partner (.i_clk_sys(i_clk_sys), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_waits(pw), .i_rd_val(rd_val), .i_hold_req(hold_req), .o_data(din),
      .o_ready_n(ready_n), .o_hold_n(hold_n));

   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end

   // pin monitor: edge times in system cycles
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      p_ale <= ale;
      p_stb <= rd_n & wr_n;
      p_ack <= hold_ack;
      p_req <= bus_req;
      p_bclk <= bclk;
      p_oe <= ctl_oe_n;
      if (!i_sys_rst) begin
         if (ale && !p_ale) begin
            t_ale <= cyc;
            n_ale <= n_ale + 1;
            a_ale <= addr;
            d_ale <= dout;
         end
         if (p_stb && !(rd_n & wr_n)) begin
            t_sf <= cyc;
            d_stb <= dout;
            s_wr <= !wr_n && rd_n;
         end
         if (!p_stb && (rd_n & wr_n)) t_sr <= cyc;
         if (hold_ack && !p_ack) t_hr <= cyc;
         if (!hold_ack && p_ack) t_hf <= cyc;
         if (!ctl_oe_n && p_oe) t_oe <= cyc;
         if ((bus_req && !hold_ack) ||
             ((hold_ack !== p_ack || bus_req !== p_req) && !(bclk && !p_bclk)))
            viol <= viol + 1;
      end
   end

   task automatic final_report();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge i_clk_sys);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge i_clk_sys);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge i_clk_sys);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge i_clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge i_clk_sys); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // one external cycle, then a hold taken right after it to time the gap
   task automatic run_cyc(input logic [7:0] ctrl, input logic wr, input logic [7:0] w,
         input int a2s, input int low, input int gap);
      logic [1:0] r;
      logic [31:0] d;
      logic [15:0] av;
      logic [15:0] wv;
      av = {ctrl, ~ctrl};
      wv = {~ctrl, 8'h3c};
      pw <= w;
      rd_val <= {ctrl, 8'h5a};
      axi_wr(ebrh_pkg::OFF_CTRL, {24'h0, ctrl}, r);
      axi_wr(ebrh_pkg::OFF_ADDR, {16'h0, av}, r);
      axi_wr(ebrh_pkg::OFF_WDATA, {16'h0, wv}, r);
      axi_wr(ebrh_pkg::OFF_CMD, {30'h0, wr, 1'b1}, r);
      `CHK(r, ebrh_pkg::RESP_OKAY)
      while ((rd_n & wr_n) !== 1'b0) @(posedge i_clk_sys);
      hold_req <= 1'b1;
      while (hold_ack !== 1'b1) @(posedge i_clk_sys);
      @(posedge i_clk_sys);
      `CHK(t_sf - t_ale, a2s)
      `CHK(t_sr - t_sf, low)
      `CHK(t_hr - t_sr, gap)
      `CHK(a_ale, av)
      if (ctrl[0]) `CHK(d_ale, av)
      if (wr) `CHK(d_stb, wv)
      `CHK(s_wr, wr)
      `CHK({ctl_oe_n, addr_oe_n, data_oe_n}, 3'b111)
      hold_req <= 1'b0;
      while (ctl_oe_n !== 1'b0) @(posedge i_clk_sys);
      @(posedge i_clk_sys);
      `CHK(t_oe - t_hf, 8)
      if (!wr) begin
         axi_rd(ebrh_pkg::OFF_RDATA, d, r);
         `CHK(d[15:0], {ctrl, 8'h5a})
      end
   endtask

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      fails++;
      final_report();
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int snap;
      {fails, total_checks, cyc, t_ale, t_sf, t_sr, t_hr, t_hf, t_oe, n_ale, viol} = '0;
      {awvalid, wvalid, bready, arvalid, rready, hold_req} = '0;
      {awaddr, araddr, wdata, pw, rd_val} = '0;
      i_sys_rst = 1'b1;
      repeat (20) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      // register reset values and unmapped places
      axi_rd(ebrh_pkg::OFF_CTRL, d, r);
      `CHK(d, {24'h0, ebrh_pkg::CTRL_RST})
      axi_rd(ebrh_pkg::OFF_STATUS, d, r);
      `CHK(d, 32'h0)
      axi_rd(6'h18, d, r);
      `CHK({d, r}, {32'h0, ebrh_pkg::RESP_SLVERR})
      axi_wr(6'h1c, 32'h1, r);
      `CHK(r, ebrh_pkg::RESP_SLVERR)
      // ctrl, write, ready delay, ale-to-strobe, strobe low, gap to hold grant
      run_cyc(8'h08, 1'b0, 8'h00, 8, 8, 8);
      run_cyc(8'h08, 1'b0, 8'h0a, 8, 16, 8);
      run_cyc(8'h28, 1'b1, 8'h00, 8, 24, 8);
      run_cyc(8'h0c, 1'b0, 8'h00, 16, 8, 8);
      run_cyc(8'h0b, 1'b1, 8'h00, 8, 8, 24);
      run_cyc(8'h09, 1'b0, 8'h00, 8, 8, 16);
      run_cyc(8'h0a, 1'b1, 8'h00, 8, 8, 16);
      run_cyc(8'h00, 1'b0, 8'h14, 8, 8, 8);
      // request the bus while it is held by the other master
      hold_req <= 1'b1;
      while (hold_ack !== 1'b1) @(posedge i_clk_sys);
      snap = n_ale;
      axi_wr(ebrh_pkg::OFF_CMD, 32'h1, r);
      repeat (24) @(posedge i_clk_sys);
      `CHK({hold_ack, bus_req, data_oe_n}, 3'b111)
      `CHK(n_ale, snap)
      axi_rd(ebrh_pkg::OFF_STATUS, d, r);
      `CHK(d[7:0], 8'hc7)
      hold_req <= 1'b0;
      while (ale !== 1'b1) @(posedge i_clk_sys);
      @(posedge i_clk_sys);
      `CHK({bus_req, t_ale > t_oe, t_oe > t_hf}, 3'b011)
      `CHK(viol, 0)
      final_report();
   end
endmodule
